// File: verilog/cmb_defines.vh
`ifndef CMB_DEFINES_VH
`define CMB_DEFINES_VH

// Frame slot geometry
`define CMB_SLOT_BYTES    13
`define CMB_NUM_TXB       3
`define CMB_RANK_W        8

// Spacing between the two controller instances, in bytes
`define CMB_INST_STRIDE   12'h200

// Word indices (byte address = 4 * index) inside one instance
`define CMB_IDX_FG        7'h00
`define CMB_IDX_TXB0      7'h10
`define CMB_IDX_TXB_LAST  7'h3f
`define CMB_TXB_RANK_K    4'hd
`define CMB_IDX_RFLG      7'h40
`define CMB_IDX_TFLG      7'h41
`define CMB_IDX_TCTL      7'h42
`define CMB_IDX_MCR0      7'h43
`define CMB_IDX_STAT      7'h44

// receive_flag_reg fields
`define CMB_RFLG_RXF      0
`define CMB_RFLG_OVR      1

// transmit_flag_reg fields: empty flags low, abort acks from bit 4
`define CMB_TFLG_ACK_LSB  4

// module_control_reg0 fields
`define CMB_MCR0_LOOP     0
`define CMB_MCR0_RXIE     1
`define CMB_MCR0_OVRIE    2
`define CMB_MCR0_TXIE_LSB 4

// Reset values
`define CMB_TXE_RST       3'h7
`define CMB_MCR0_RST      7'h00
`define CMB_TX_PIN_RST    1'h1

`endif

// File: verilog/cmb_tx_select.v
`timescale 1ns/1ps
`default_nettype none

// Picks the ready buffer with the lowest rank; ties go to the lower index
module cmb_tx_select #(
  parameter N      = 3,
  parameter RANK_W = 8,
  parameter IDX_W  = 2
) (
  input  wire [N-1:0]        ready,
  input  wire [N*RANK_W-1:0] ranks,
  output reg                 sel_valid,
  output reg  [IDX_W-1:0]    sel_idx
);

  wire [N-1:0] win;

  // Buffer i wins when every other ready buffer ranks worse
  genvar i, j;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_cand
      wire [N-1:0] beats;
      for (j = 0; j < N; j = j + 1) begin : g_vs
        if (i == j) begin : g_self
          assign beats[j] = 1'b1;
        end else begin : g_other
          wire [RANK_W-1:0] ri = ranks[i*RANK_W +: RANK_W];
          wire [RANK_W-1:0] rj = ranks[j*RANK_W +: RANK_W];
          assign beats[j] = !ready[j] || (ri < rj) || ((ri == rj) && (i < j));
        end
      end
      assign win[i] = ready[i] && (&beats);
    end
  endgenerate

  // One-hot winner to index
  integer k;
  always @* begin
    sel_valid = 1'b0;
    sel_idx   = {IDX_W{1'b0}};
    for (k = 0; k < N; k = k + 1) begin
      if (win[k]) begin
        sel_valid = 1'b1;
        sel_idx   = k[IDX_W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: verilog/cmb_msg_buffers.v
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_defines.vh"

module cmb_msg_buffers #(
  parameter INST = 0
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bus_rx_pin,
  output reg         bus_tx_pin,
  output wire        core_rx_dominant,
  input  wire        core_tx_dominant,
  input  wire        rx_byte_we,
  input  wire [3:0]  rx_byte_idx,
  input  wire [7:0]  rx_byte_data,
  input  wire        rx_frame_ok,
  input  wire        rx_accepted,
  input  wire        rx_own,
  input  wire        tx_arb_req,
  input  wire        tx_done,
  input  wire        tx_error,
  input  wire        tx_arb_lost,
  output wire        tx_sel_valid,
  output wire [1:0]  tx_sel_idx,
  output wire        tx_pending,
  input  wire [3:0]  tx_rd_idx,
  output reg  [7:0]  tx_rd_data,
  output wire        rx_irq,
  output wire        tx_irq,
  output wire        ovr_irq
);

  localparam NB = `CMB_NUM_TXB;
  localparam SB = `CMB_SLOT_BYTES;
  localparam [NB-1:0] TXE_RST = `CMB_TXE_RST;

  // Slot storage
  reg [7:0] bg_mem_ff [0:SB-1];
  reg [7:0] fg_mem_ff [0:SB-1];
  reg [7:0] tx_mem_ff [0:63];
  reg [`CMB_RANK_W-1:0] rank_ff [0:NB-1];

  // Control and status state
  reg          rx_s1_ff;
  reg          rx_s2_ff;
  reg          rxf_ff;
  reg          bg_pend_ff;
  reg          ovr_ff;
  reg [NB-1:0] txe_ff;
  reg [NB-1:0] abt_ff;
  reg [NB-1:0] ack_ff;
  reg          busy_ff;
  reg [1:0]    active_ff;
  reg [6:0]    mcr0_ff;
  reg [31:0]   rd_val;
  reg          map_ok;

  wire [6:0] word     = paddr[8:2];
  wire       inst_hit = (paddr[11:9] == INST[2:0]);
  wire       acc      = psel && penable;
  wire       wr       = acc && pwrite && map_ok;
  wire       fg_hit   = (word < SB[6:0]);
  wire       tx_hit   = (word >= `CMB_IDX_TXB0) && (word <= `CMB_IDX_TXB_LAST) &&
                        (word[3:0] <= `CMB_TXB_RANK_K);
  wire [1:0] tx_b     = word[5:4] - 2'h1;
  wire [3:0] tx_k     = word[3:0];
  wire       loop_en  = mcr0_ff[`CMB_MCR0_LOOP];

  // Zero-wait slave; unmapped or foreign-instance accesses flag an error
  assign pready  = 1'b1;
  assign pslverr = acc && !map_ok;

  // Address decode and read mux
  always @* begin
    map_ok = 1'b0;
    rd_val = 32'h0000_0000;
    if (inst_hit) begin
      if (fg_hit) begin
        map_ok = 1'b1;
        rd_val = {24'h00_0000, fg_mem_ff[word[3:0]]};
      end else if (tx_hit) begin
        map_ok = 1'b1;
        if (tx_k == `CMB_TXB_RANK_K)
          rd_val = {24'h00_0000, rank_ff[tx_b]};
        else
          rd_val = {24'h00_0000, tx_mem_ff[{tx_b, tx_k}]};
      end else begin
        case (word)
          `CMB_IDX_RFLG: begin
            map_ok = 1'b1;
            rd_val = {30'h0, ovr_ff, rxf_ff};
          end
          `CMB_IDX_TFLG: begin
            map_ok = 1'b1;
            rd_val = {25'h0, ack_ff, 1'b0, txe_ff};
          end
          `CMB_IDX_TCTL: begin
            map_ok = 1'b1;
            rd_val = {29'h0, abt_ff};
          end
          `CMB_IDX_MCR0: begin
            map_ok = 1'b1;
            rd_val = {25'h0, mcr0_ff};
          end
          `CMB_IDX_STAT: begin
            map_ok = 1'b1;
            rd_val = {28'h0, bg_pend_ff, busy_ff, active_ff};
          end
          default: begin
            map_ok = 1'b0;
            rd_val = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Read data captured in the setup cycle, held through the access phase
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // Pins: receive synchroniser and registered transmit level
  assign core_rx_dominant = !rx_s2_ff;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_s1_ff   <= 1'b1;
      rx_s2_ff   <= 1'b1;
      bus_tx_pin <= `CMB_TX_PIN_RST;
    end else begin
      rx_s1_ff   <= bus_rx_pin;
      rx_s2_ff   <= rx_s1_ff;
      bus_tx_pin <= !core_tx_dominant;
    end
  end

  // Receive queue events
  wire accept_evt = rx_frame_ok && rx_accepted && (!rx_own || loop_en);
  wire rxf_clr    = wr && (word == `CMB_IDX_RFLG) && pwdata[`CMB_RFLG_RXF];
  wire ovr_clr    = wr && (word == `CMB_IDX_RFLG) && pwdata[`CMB_RFLG_OVR];
  wire reload     = rxf_clr && rxf_ff && bg_pend_ff;
  wire copy_now   = (accept_evt && !rxf_ff) || reload;
  wire park_evt   = accept_evt && rxf_ff && !bg_pend_ff;
  wire ovr_evt    = accept_evt && rxf_ff && bg_pend_ff;

  // Background takes every frame's bytes unless it holds a parked frame
  always @(posedge clock) begin
    if (rx_byte_we && !bg_pend_ff && (rx_byte_idx < SB[3:0])) begin
      bg_mem_ff[rx_byte_idx] <= rx_byte_data;
    end
  end

  // Foreground copy, all bytes in one cycle
  genvar gb;
  generate
    for (gb = 0; gb < SB; gb = gb + 1) begin : g_fg
      always @(posedge clock) begin
        if (copy_now) begin
          fg_mem_ff[gb] <= bg_mem_ff[gb];
        end
      end
    end
  endgenerate

  // Receive flags; a set in the same cycle as a clear wins
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxf_ff     <= 1'b0;
      bg_pend_ff <= 1'b0;
      ovr_ff     <= 1'b0;
    end else begin
      if (copy_now)
        rxf_ff <= 1'b1;
      else if (rxf_clr)
        rxf_ff <= 1'b0;
      if (park_evt)
        bg_pend_ff <= 1'b1;
      else if (reload)
        bg_pend_ff <= 1'b0;
      if (ovr_evt)
        ovr_ff <= 1'b1;
      else if (ovr_clr)
        ovr_ff <= 1'b0;
    end
  end

  // Module control register
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mcr0_ff <= `CMB_MCR0_RST;
    end else if (wr && (word == `CMB_IDX_MCR0)) begin
      mcr0_ff <= pwdata[6:0];
    end
  end

  // Transmit buffer contents, writable only while the buffer is empty
  always @(posedge clock) begin
    if (wr && tx_hit && txe_ff[tx_b]) begin
      if (tx_k == `CMB_TXB_RANK_K)
        rank_ff[tx_b] <= pwdata[`CMB_RANK_W-1:0];
      else
        tx_mem_ff[{tx_b, tx_k}] <= pwdata[7:0];
    end
  end

  // Byte fetch for the protocol engine from the active buffer
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_rd_data <= 8'h00;
    end else begin
      tx_rd_data <= tx_mem_ff[{active_ff, tx_rd_idx}];
    end
  end

  // Selection among ready buffers
  wire                     sel_valid;
  wire [1:0]               sel_idx;
  wire [NB*`CMB_RANK_W-1:0] rank_flat = {rank_ff[2], rank_ff[1], rank_ff[0]};

  cmb_tx_select #(
    .N      (NB),
    .RANK_W (`CMB_RANK_W),
    .IDX_W  (2)
  ) u_sel (
    .ready     (~txe_ff),
    .ranks     (rank_flat),
    .sel_valid (sel_valid),
    .sel_idx   (sel_idx)
  );

  // Transmission ownership: chosen afresh at each arbitration attempt
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_ff   <= 1'b0;
      active_ff <= 2'h0;
    end else if (busy_ff) begin
      if (tx_done || tx_error || tx_arb_lost)
        busy_ff <= 1'b0;
    end else if (tx_arb_req && sel_valid) begin
      busy_ff   <= 1'b1;
      active_ff <= sel_idx;
    end
  end

  assign tx_sel_valid = busy_ff;
  assign tx_sel_idx   = active_ff;
  assign tx_pending   = |(~txe_ff);

  // Per-buffer empty, abort request and abort acknowledge
  genvar gt;
  generate
    for (gt = 0; gt < NB; gt = gt + 1) begin : g_txb
      wire in_tx    = busy_ff && (active_ff == gt);
      wire done_i   = tx_done && in_tx;
      wire abort_ok = abt_ff[gt] && !txe_ff[gt] && !in_tx;
      wire host_clr = wr && (word == `CMB_IDX_TFLG) && pwdata[gt];
      wire abt_wr   = wr && (word == `CMB_IDX_TCTL);
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          txe_ff[gt] <= TXE_RST[gt];
          abt_ff[gt] <= 1'b0;
          ack_ff[gt] <= 1'b0;
        end else begin
          if (done_i || abort_ok)
            txe_ff[gt] <= 1'b1;
          else if (host_clr)
            txe_ff[gt] <= 1'b0;
          if (done_i || abort_ok || txe_ff[gt])
            abt_ff[gt] <= 1'b0;
          else if (abt_wr)
            abt_ff[gt] <= pwdata[gt];
          if (abort_ok)
            ack_ff[gt] <= 1'b1;
          else if (done_i || host_clr)
            ack_ff[gt] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt levels, gated by enables
  assign rx_irq  = rxf_ff && mcr0_ff[`CMB_MCR0_RXIE];
  assign ovr_irq = ovr_ff && mcr0_ff[`CMB_MCR0_OVRIE];
  assign tx_irq  = |(txe_ff & mcr0_ff[`CMB_MCR0_TXIE_LSB +: NB]);

endmodule

`default_nettype wire

// File: bench/cmb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far node on a wired-AND bus behind the transceiver
module cmb_bus_model (
  input  wire logic bus_tx_pin,
  input  wire logic remote_dom,
  output wire logic bus_rx_pin
);
  // Low level is dominant and wins over high
  assign bus_rx_pin = bus_tx_pin & ~remote_dom;
endmodule
`default_nettype wire

// File: bench/cmb_msg_buffers_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffers_asserts #(
  parameter INST = 0
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        bus_tx_pin,
  input wire logic        core_tx_dominant,
  input wire logic        rx_frame_ok,
  input wire logic        rx_accepted,
  input wire logic        rx_irq,
  input wire logic        tx_arb_req,
  input wire logic        tx_done,
  input wire logic        tx_error,
  input wire logic        tx_arb_lost,
  input wire logic        tx_sel_valid,
  input wire logic [1:0]  tx_sel_idx,
  input wire logic        tx_pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // End of an attempt, and a host write in flight
  wire tx_end = tx_done | tx_error | tx_arb_lost;
  wire wr_acc = psel & penable & pwrite;
  property p_pin; $past(rstn) |-> bus_tx_pin == !$past(core_tx_dominant); endproperty
  property p_err; psel && penable && paddr[11:9] != 3'(INST) |-> pslverr; endproperty
  property p_errph;
    psel && penable && paddr[11:9] == 3'(INST) && paddr[8:2] < 7'h0d |-> !pslverr;
  endproperty
  property p_rej; rx_frame_ok && !rx_accepted && !rx_irq && !wr_acc |=> !rx_irq; endproperty
  property p_sel; tx_arb_req && !tx_sel_valid && tx_pending && !wr_acc |=> tx_sel_valid; endproperty
  property p_idle; tx_arb_req && !tx_pending && !tx_sel_valid |=> !tx_sel_valid; endproperty
  property p_hold; tx_sel_valid && !tx_end |=> tx_sel_valid && $stable(tx_sel_idx); endproperty
  property p_end; tx_sel_valid && tx_end ##1 !tx_arb_req |-> !tx_sel_valid; endproperty
  a_pin: assert property (p_pin) else $error("tx pin level");
  a_err: assert property (p_err) else $error("foreign address");
  a_errph: assert property (p_errph) else $error("foreground window refused");
  a_rej: assert property (p_rej) else $error("rejected frame irq");
  a_sel: assert property (p_sel) else $error("no selection");
  a_idle: assert property (p_idle) else $error("selection when idle");
  a_hold: assert property (p_hold) else $error("owned buffer dropped");
  a_end: assert property (p_end) else $error("attempt not ended");
  c_done: cover property (tx_sel_valid && tx_done);
  c_lost: cover property (tx_sel_valid && tx_arb_lost);
  c_err: cover property (pslverr);
endmodule
bind cmb_msg_buffers cmb_msg_buffers_asserts #(.INST(INST)) u_chk (.clock, .rstn, .psel,
  .penable, .pwrite, .paddr, .pslverr, .bus_tx_pin, .core_tx_dominant, .rx_frame_ok,
  .rx_accepted, .rx_irq, .tx_arb_req, .tx_done, .tx_error, .tx_arb_lost, .tx_sel_valid,
  .tx_sel_idx, .tx_pending);
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmb_defines.vh"
module tb_top;
  logic        clock = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        core_tx_dominant = 1'h0;
  logic        remote_dom = 1'h0;
  logic        rx_byte_we = 1'h0;
  logic [3:0]  rx_byte_idx = 4'h0;
  logic [7:0]  rx_byte_data = 8'h0;
  logic [2:0]  rxc = 3'h0;
  logic [3:0]  txc = 4'h0;
  logic [3:0]  tx_rd_idx = 4'hc;
  logic [31:0] rd;
  logic [31:0] err;
  wire  [31:0] prdata;
  wire  [7:0]  tx_rd_data;
  wire  [1:0]  tx_sel_idx;
  wire         pready, pslverr, bus_rx_pin, bus_tx_pin, core_rx_dominant;
  wire         tx_sel_valid, tx_pending, rx_irq, tx_irq, ovr_irq;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  // Ranks of buffers 0..2, expected send order in the low six bits
  logic [31:0] rows [3] = '{32'h30102018, 32'h05050121, 32'h00800009};
  cmb_msg_buffers #(.INST(0)) dut (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bus_rx_pin, .bus_tx_pin, .core_rx_dominant, .core_tx_dominant, .rx_byte_we,
    .rx_byte_idx, .rx_byte_data, .rx_frame_ok(rxc[0]), .rx_accepted(rxc[1]), .rx_own(rxc[2]),
    .tx_arb_req(txc[0]), .tx_done(txc[1]), .tx_error(txc[2]), .tx_arb_lost(txc[3]),
    .tx_sel_valid, .tx_sel_idx, .tx_pending, .tx_rd_idx, .tx_rd_data, .rx_irq, .tx_irq, .ovr_irq
  );
  cmb_bus_model bus (.bus_tx_pin, .remote_dom, .bus_rx_pin);
  always #5 clock = ~clock;
  // Cut a hung run short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    rd = prdata;
    err = 32'(pslverr);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [6:0] ix, input logic [31:0] d);
    apb(1'h1, {3'h0, ix, 2'h0}, d);
  endtask
  task automatic rdc(input string nm, input logic [6:0] ix, input logic [31:0] exp);
    apb(1'h0, {3'h0, ix, 2'h0}, 32'h0);
    chk(nm, rd, exp);
  endtask
  function automatic logic [6:0] tix(input int b, input int k);
    return 7'(`CMB_IDX_TXB0 + 16 * b + k);
  endfunction
  // Thirteen bytes into the background, then the frame end
  task automatic frame(input logic [7:0] b, input logic [2:0] q);
    for (int k = 0; k < 13; k++) begin
      @(posedge clock);
      rx_byte_we <= 1'h1;
      rx_byte_idx <= 4'(k);
      rx_byte_data <= b + 8'(k);
    end
    @(posedge clock);
    rx_byte_we <= 1'h0;
    @(posedge clock);
    rxc <= q;
    @(posedge clock);
    rxc <= 3'h0;
  endtask
  task automatic txp(input logic [3:0] v);
    @(posedge clock);
    txc <= v;
    @(posedge clock);
    txc <= 4'h0;
    @(posedge clock);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    chk("pin_rst", bus_tx_pin, 1);
    rstn <= 1'h1;
    rdc("tflg_rst", `CMB_IDX_TFLG, 32'h7);
    wr(`CMB_IDX_MCR0, 32'h76);
    // Rank table: three sends per row, lowest rank first
    foreach (rows[i]) begin
      for (int b = 0; b < 3; b++) begin
        wr(tix(b, 13), rows[i] >> (24 - 8 * b) & 32'hff);
        wr(tix(b, 12), 32'h40 + 32'(b));
      end
      wr(`CMB_IDX_TFLG, 32'h7);
      for (int n = 0; n < 3; n++) begin
        txp(4'h1);
        chk("sel_idx", tx_sel_idx, rows[i] >> (4 - 2 * n) & 32'h3);
        // Byte fetch lags the selection by one edge
        @(posedge clock);
        chk("tx_byte", tx_rd_data, 32'h40 + (rows[i] >> (4 - 2 * n) & 32'h3));
        txp(4'h2);
      end
      rdc("tflg_done", `CMB_IDX_TFLG, 32'h7);
      chk("tx_irq", tx_irq, 1);
      chk("idle_pend", tx_pending, 0);
    end
    $display("test rank done");
    // Receive queue: fill, park, overrun, reload
    frame(8'ha0, 3'h3);
    rdc("rxf", `CMB_IDX_RFLG, 32'h1);
    chk("rx_irq", rx_irq, 1);
    rdc("fg_last", 7'h0c, 32'hac);
    frame(8'hb0, 3'h1);
    rdc("fg_keep", 7'h00, 32'ha0);
    frame(8'hc0, 3'h3);
    frame(8'hd0, 3'h3);
    rdc("ovr", `CMB_IDX_RFLG, 32'h3);
    chk("ovr_irq", ovr_irq, 1);
    // Transmit stays usable while full; error and loss reselect
    wr(tix(2, 13), 32'h50);
    wr(`CMB_IDX_TFLG, 32'h4);
    txp(4'h1);
    chk("full_tx", tx_sel_idx, 2);
    chk("busy_pend", tx_pending, 1);
    wr(tix(0, 13), 32'h01);
    wr(`CMB_IDX_TFLG, 32'h1);
    txp(4'h4);
    txp(4'h1);
    chk("retry", tx_sel_idx, 0);
    txp(4'h8);
    chk("lost", tx_sel_valid, 0);
    txp(4'h1);
    txp(4'h2);
    txp(4'h1);
    txp(4'h2);
    rdc("tx_all", `CMB_IDX_TFLG, 32'h7);
    wr(`CMB_IDX_RFLG, 32'h0);
    rdc("w0", `CMB_IDX_RFLG, 32'h3);
    wr(`CMB_IDX_RFLG, 32'h3);
    rdc("reload", `CMB_IDX_RFLG, 32'h1);
    rdc("fg_c", 7'h00, 32'hc0);
    wr(`CMB_IDX_RFLG, 32'h1);
    rdc("rxf_clr", `CMB_IDX_RFLG, 32'h0);
    frame(8'h90, 3'h1);
    rdc("rej", `CMB_IDX_RFLG, 32'h0);
    frame(8'he0, 3'h7);
    rdc("own", `CMB_IDX_RFLG, 32'h0);
    wr(`CMB_IDX_MCR0, 32'h77);
    frame(8'hf0, 3'h7);
    rdc("loop_fg", 7'h00, 32'hf0);
    $display("test receive done");
    // Abort: idle buffer granted, active buffer sent
    wr(tix(0, 13), 32'h10);
    wr(tix(1, 13), 32'h20);
    wr(`CMB_IDX_TFLG, 32'h3);
    txp(4'h1);
    wr(`CMB_IDX_TCTL, 32'h3);
    rdc("abort", `CMB_IDX_TFLG, 32'h26);
    txp(4'h2);
    rdc("ab_sent", `CMB_IDX_TFLG, 32'h27);
    apb(1'h0, 12'h200, 32'h0);
    chk("slverr", err, 1);
    core_tx_dominant <= 1'h1;
    repeat (4) @(posedge clock);
    chk("pin_dom", bus_tx_pin, 0);
    chk("rx_dom", core_rx_dominant, 1);
    $display("test misc done");
    wrap_up();
  end
endmodule
`default_nettype wire
